//--- shared/period_timer_pkg.sv
package period_timer_pkg;
    // register byte addresses, one aligned 32-bit word each
    localparam logic [3:0] ADDR_COUNT = 4'h0;
    localparam logic [3:0] ADDR_PERIOD = 4'h4;
    localparam logic [3:0] ADDR_CONTROL = 4'h8;
    localparam logic [3:0] ADDR_FLAGS = 4'hC;
    // control field positions
    localparam int CTL_PRE_LSB = 0;
    localparam int CTL_RUN_BIT = 2;
    localparam int CTL_POST_LSB = 3;
    // flag register field position
    localparam int FLG_MATCH_BIT = 1;
    // reset values
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] PERIOD_RST = 8'hFF;
    localparam logic [6:0] CONTROL_RST = 7'h00;
    // instruction clock is the system clock divided by four
    localparam int INSTR_DIV = 4;
    // prescale select encodings
    typedef enum logic [1:0] {
        PRE_DIV1 = 2'h0,
        PRE_DIV4 = 2'h1,
        PRE_DIV64 = 2'h2,
        PRE_DIV64B = 2'h3
    } prescale_t;
endpackage : period_timer_pkg

//--- shared/scaler_if.sv
`timescale 1ns/1ps
// carries the tick chain between the counter core and the scaler stage
interface scaler_if;
    logic instr_tick;
    logic count_tick;
    logic clear;
    logic [1:0] prescale_sel;
    modport core (input count_tick, output instr_tick, output clear, output prescale_sel);
    modport scaler (output count_tick, input instr_tick, input clear, input prescale_sel);
endinterface : scaler_if

//--- src/prescaler.sv
`timescale 1ns/1ps
// divides instruction ticks by 1, 4 or 64 into counter ticks
module prescaler (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    scaler_if.scaler sif
);
    logic [5:0] pre_cnt_r;
    logic [5:0] pre_cnt_nxt;
    logic [5:0] pre_limit;
    logic pre_wrap;
    logic count_tick_r;

    // 2'h3 also selects 64, as the top encoding mirrors the widest ratio
    assign pre_limit = (sif.prescale_sel == period_timer_pkg::PRE_DIV1) ? 6'h00 :
                       (sif.prescale_sel == period_timer_pkg::PRE_DIV4) ? 6'h03 : 6'h3F; // [RULE2]
    assign pre_wrap = sif.instr_tick && (pre_cnt_r >= pre_limit);
    assign pre_cnt_nxt = pre_wrap ? 6'h00 : pre_cnt_r + 6'h01;

    // prescale counter, cleared by counter writes, control writes and reset
    always_ff @(posedge clk) begin
        if (srst) begin
            pre_cnt_r <= 6'h00;
            count_tick_r <= 1'b0;
        end else if (ce) begin
            if (sif.clear) begin // [RULE12]
                pre_cnt_r <= 6'h00;
                count_tick_r <= 1'b0;
            end else begin
                if (sif.instr_tick) begin
                    pre_cnt_r <= pre_cnt_nxt;
                end
                count_tick_r <= pre_wrap; // [RULE2]
            end
        end
    end

    assign sif.count_tick = count_tick_r;
endmodule : prescaler

//--- src/period_match_timer.sv
// Contract
// [RULE1] counting clock is the instruction clock, system clock divided by four
// [RULE2] prescaler divides by one, four or sixty-four; each output increments counter
// [RULE3] counter is compared continuously with the period, counting up from zero
// [RULE4] on a match the next increment loads zero instead
// [RULE5] each match advances the postscaler by one
// [RULE6] postscaler ratios one through sixteen, one event per selected matches
// [RULE7] each postscaler event sets the match flag in the flag register
// [RULE8] counter and period registers are readable and writable at any time
// [RULE9] reset clears the counter and sets the period to all ones
// [RULE10] run bit set starts counting, clear stops it
// [RULE11] prescale and postscale selects live in the control register
// [RULE12] scaler counts clear on counter write, control write and reset
// [RULE13] control write leaves the counter untouched but clears scalers
// [RULE14] counter and period are eight bits wide
// [RULE15] with run clear nothing counts, matches, advances or sets the flag; the prescaler here still counts instruction ticks
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module period_match_timer #(
    parameter int COUNT_W = 8
) (
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic CE,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic WB_ERR_O,
    output logic TIMER_MATCH_FLAG,
    output logic POSTSCALE_EVENT
);
    // the counter and period registers are fixed at 8 bits wide
    initial begin
        if (COUNT_W != 8) begin
            $error("period_match_timer supports only COUNT_W of 8");
        end
    end

    scaler_if sif ();

    logic [1:0] instr_div_r;
    logic instr_tick_r;
    logic [7:0] timer_count_r;
    logic [7:0] timer_count_nxt;
    logic [7:0] period_value_r;
    logic [6:0] timer_control_r;
    logic [3:0] post_cnt_r;
    logic [3:0] post_cnt_nxt;
    logic timer_match_flag_r;
    logic post_event_r;
    logic ack_r;
    logic err_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic clear_r;

    // bus decode
    wire req = WB_CYC_I && WB_STB_I && !ack_r && !err_r;
    wire lane0 = WB_SEL_I[0];
    wire hit_count = (WB_ADR_I == period_timer_pkg::ADDR_COUNT);
    wire hit_period = (WB_ADR_I == period_timer_pkg::ADDR_PERIOD);
    wire hit_control = (WB_ADR_I == period_timer_pkg::ADDR_CONTROL);
    wire hit_flags = (WB_ADR_I == period_timer_pkg::ADDR_FLAGS);
    wire mapped = hit_count || hit_period || hit_control || hit_flags;
    wire wr = req && WB_WE_I && lane0 && mapped;
    wire wr_count = wr && hit_count;
    wire wr_period = wr && hit_period;
    wire wr_control = wr && hit_control;
    wire wr_flags = wr && hit_flags;

    // control fields
    wire timer_run = timer_control_r[period_timer_pkg::CTL_RUN_BIT];
    wire [1:0] prescale_select = timer_control_r[period_timer_pkg::CTL_PRE_LSB +: 2]; // [RULE11]
    wire [3:0] postscale_select = timer_control_r[period_timer_pkg::CTL_POST_LSB +: 4]; // [RULE11]

    // match and advance terms
    wire count_step = timer_run && sif.count_tick && !clear_r; // [RULE15]
    wire match = (timer_count_r == period_value_r); // [RULE3]
    wire match_step = count_step && match; // [RULE5]
    wire post_fire = match_step && (post_cnt_r == postscale_select); // [RULE6]

    // counter next value: wrap to zero after a match
    assign timer_count_nxt = match ? period_timer_pkg::COUNT_RST
                                   : timer_count_r + 8'h01; // [RULE4]
    assign post_cnt_nxt = post_fire ? 4'h0 : post_cnt_r + 4'h1;

    // read mux, unused bits read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (hit_count) begin
            rdata_nxt[7:0] = timer_count_r; // [RULE8]
        end else if (hit_period) begin
            rdata_nxt[7:0] = period_value_r; // [RULE8]
        end else if (hit_control) begin
            rdata_nxt[6:0] = timer_control_r;
        end else if (hit_flags) begin
            rdata_nxt[period_timer_pkg::FLG_MATCH_BIT] = timer_match_flag_r;
        end
    end

    // instruction clock divider: one tick every four system clocks
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            instr_div_r <= 2'h0;
            instr_tick_r <= 1'b0;
        end else if (CE) begin
            instr_div_r <= instr_div_r + 2'h1; // [RULE1]
            instr_tick_r <= (instr_div_r == 2'(period_timer_pkg::INSTR_DIV - 1)); // [RULE1]
        end
    end

    // scaler clear pulse follows the write that caused it
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            clear_r <= 1'b0;
        end else if (CE) begin
            clear_r <= wr_count || wr_control; // [RULE12]
        end
    end

    assign sif.instr_tick = instr_tick_r;
    assign sif.clear = clear_r || wr_count || wr_control; // [RULE12]
    assign sif.prescale_sel = prescale_select;

    prescaler u_prescaler (
        .clk(CLK_SYS),
        .srst(SRST),
        .ce(CE),
        .sif(sif)
    );

    // counter: software write beats a tick in the same cycle
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            timer_count_r <= period_timer_pkg::COUNT_RST; // [RULE9]
        end else if (CE) begin
            if (wr_count) begin
                timer_count_r <= WB_DAT_I[7:0]; // [RULE8]
            end else if (count_step) begin // [RULE10]
                timer_count_r <= timer_count_nxt; // [RULE2]
            end
        end
    end

    // period register
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            period_value_r <= period_timer_pkg::PERIOD_RST; // [RULE9]
        end else if (CE && wr_period) begin
            period_value_r <= WB_DAT_I[7:0]; // [RULE8]
        end
    end

    // control register; writing it never touches the counter
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            timer_control_r <= period_timer_pkg::CONTROL_RST;
        end else if (CE && wr_control) begin
            timer_control_r <= WB_DAT_I[6:0]; // [RULE13]
        end
    end

    // postscaler count
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            post_cnt_r <= 4'h0;
        end else if (CE) begin
            if (wr_count || wr_control || clear_r) begin
                post_cnt_r <= 4'h0; // [RULE12]
            end else if (match_step) begin
                post_cnt_r <= post_cnt_nxt; // [RULE5]
            end
        end
    end

    // sticky flag: a postscale event wins over a software clear
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            timer_match_flag_r <= 1'b0;
            post_event_r <= 1'b0;
        end else if (CE) begin
            post_event_r <= post_fire;
            if (post_fire) begin
                timer_match_flag_r <= 1'b1; // [RULE7]
            end else if (wr_flags) begin
                timer_match_flag_r <= WB_DAT_I[period_timer_pkg::FLG_MATCH_BIT];
            end
        end
    end

    // single-cycle answer, err on unmapped address
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else if (CE) begin
            ack_r <= req && mapped;
            err_r <= req && !mapped;
            if (req) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign WB_ACK_O = ack_r;
    assign WB_ERR_O = err_r;
    assign WB_DAT_O = rdata_r;
    assign TIMER_MATCH_FLAG = timer_match_flag_r;
    assign POSTSCALE_EVENT = post_event_r;
endmodule : period_match_timer

//--- tb/period_match_timer_chk.sv
`timescale 1ns/1ps
module period_match_timer_chk (
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic CE,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic WB_ERR_O,
    input wire logic TIMER_MATCH_FLAG,
    input wire logic POSTSCALE_EVENT
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    // a new request is one not already answered
    wire req = WB_CYC_I && WB_STB_I && CE && !WB_ACK_O && !WB_ERR_O;
    wire mapped = WB_ADR_I[1:0] == 2'h0;
    wire sw_write = WB_CYC_I && WB_STB_I && WB_WE_I;
    a_ack_pulse: assert property (WB_ACK_O && CE |=> !WB_ACK_O)
        else $error("ack held past one cycle");
    a_bus_answer: assert property (req && mapped |=> WB_ACK_O && !WB_ERR_O)
        else $error("mapped access not acked next cycle");
    a_err_unmapped: assert property (req && !mapped |=> WB_ERR_O && !WB_ACK_O)
        else $error("unmapped access not refused");
    a_upper_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
        else $error("read data wider than eight bits");
    a_flag_event: assert property (POSTSCALE_EVENT |-> TIMER_MATCH_FLAG)
        else $error("event without match flag");
    a_flag_sticky: assert property (TIMER_MATCH_FLAG && !sw_write |=> TIMER_MATCH_FLAG)
        else $error("match flag dropped by itself");
    // ticks come every fourth clock at the fastest
    a_event_space: assert property (POSTSCALE_EVENT |=> !POSTSCALE_EVENT [*3])
        else $error("events closer than four clocks");
    // enable low freezes the ack and match flag outputs
    a_freeze_hold: assert property (!CE |=> $stable(WB_ACK_O) && $stable(TIMER_MATCH_FLAG))
        else $error("outputs moved while enable low");
    a_reset_quiet: assert property (disable iff (1'b0) SRST |=>
        !WB_ACK_O && !WB_ERR_O && !TIMER_MATCH_FLAG && !POSTSCALE_EVENT)
        else $error("outputs active after reset");
endmodule : period_match_timer_chk
bind period_match_timer period_match_timer_chk period_match_timer_chk_i (.CLK_SYS(CLK_SYS),
    .SRST(SRST), .CE(CE), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O),
    .TIMER_MATCH_FLAG(TIMER_MATCH_FLAG), .POSTSCALE_EVENT(POSTSCALE_EVENT));

//--- tb/period_match_timer_tb.sv
`timescale 1ns/1ps
module period_match_timer_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack, err, flag, ev;
    logic ce = 1'b1;
    int bad_count = 0;
    int n_compared = 0;
    int mdl[4];
    always #5 clk = ~clk;
    // sel held at all lanes; lane masking is left untested
    period_match_timer period_match_timer_i (.CLK_SYS(clk), .SRST(srst), .CE(ce),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .WB_ERR_O(err),
        .TIMER_MATCH_FLAG(flag), .POSTSCALE_EVENT(ev));
    task automatic close_out();
        if (bad_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            bad_count++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    // one classic cycle, entered and left just after a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        if (n == 20) begin
            bad_count++;
            close_out();
        end
        q = rdat;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic wr(input logic [3:0] a, input int d);
        logic [31:0] q;
        logic e;
        mdl[a[3:2]] = d & ((a == 4'h8) ? 127 : (a == 4'hC) ? 2 : 255);
        bus(1'b1, a, 32'(d), q, e);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        logic [31:0] q;
        logic e;
        bus(1'b0, a, 32'h0, q, e);
        check(q, mdl[a[3:2]]);
    endtask : rd
    // clocks between two steady events, skipping the first after a setup
    task automatic gap(input int want);
        int n;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (ev !== 1'b1 && n < 5000);
        end
        if (n == 5000) begin
            bad_count++;
            close_out();
        end
        check(n, want);
    endtask : gap
    initial begin
        logic [31:0] q;
        logic e;
        int p, post, div;
        void'($urandom(32'hA186));
        mdl = '{0, 255, 0, 0};
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 16; a += 4) rd(4'(a));
        bus(1'b0, 4'h2, 32'h0, q, e);
        check(e, 1);
        wr(4'h0, 32'h5A);
        rd(4'h0);
        wr(4'h4, 32'hA5);
        rd(4'h4);
        wr(4'h8, 32'h7B);
        rd(4'h8);
        rd(4'h0);
        repeat (50) @(posedge clk);
        rd(4'h0);
        check(flag, 0);
        // enable low freezes the running counter; only bus clocks may tick
        wr(4'h4, 255);
        wr(4'h0, 0);
        wr(4'h8, 4);
        bus(1'b0, 4'h0, 32'h0, q, e);
        ce <= 1'b0;
        repeat (200) @(posedge clk);
        ce <= 1'b1;
        @(posedge clk);
        p = int'(q[7:0]);
        bus(1'b0, 4'h0, 32'h0, q, e);
        check(32'(int'(q[7:0]) - p < 3), 1);
        // every prescale code, random period and postscale
        for (int ps = 0; ps < 4; ps++) begin
            div = (ps == 0) ? 1 : (ps == 1) ? 4 : 64;
            p = $urandom_range((ps < 2) ? 7 : 1, 0);
            post = $urandom_range((ps < 2) ? 3 : 1, 0);
            wr(4'h4, p);
            wr(4'h0, 0);
            wr(4'h8, post * 8 + 4 + ps);
            gap((p + 1) * div * 4 * (post + 1));
            check(flag, 1);
        end
        wr(4'h8, 0);
        mdl[3] = 2;
        rd(4'hC);
        wr(4'hC, 0);
        check(flag, 0);
        // reset in mid-run
        wr(4'h4, 3);
        wr(4'h8, 4);
        repeat (40) @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        mdl = '{0, 255, 0, 0};
        @(posedge clk);
        check(flag, 0);
        for (int a = 0; a < 16; a += 4) rd(4'(a));
        close_out();
    end
endmodule : period_match_timer_tb
